// >>> oag_pkg.sv
// Shared types and constants of the operand address generator
// -----------------------------------------------------------------------------
// How it works
// - Indirect address read from lower-file word register
// - Indirect address may target any location
// - Only one memory operand per instruction
// - Extended indirect uses 24-bit pointer register
// - Autoincrement adds one for byte, two word
// - Pointer field bit zero selects autoincrement
// - Extended indirect autoincrement updates 24-bit pointer
// - Stack pointer accepted as indirect pointer
// - Short index adds 8-bit constant to base
// - Short reach 255, long 65535, zero 65535
// - Long index adds 16-bit constant to register
// - Stack pointer accepted as short-index base
// - Extended index adds 24-bit offset to base
// - Zero index uses 16-bit instruction address, 24-bit when extended
// - Zero register is 32-bit zero source
// - Direct references bypass the memory controller
// -----------------------------------------------------------------------------
package oag_pkg;
   localparam logic [7:0] ZERO_REG_ADDR = 8'h00;
   localparam logic [7:0] PTR_FIELD_MASK = 8'hfe;
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   localparam logic [23:0] INC_BYTE = 24'h000001;
   localparam logic [23:0] INC_WORD = 24'h000002;

   typedef enum logic [2:0] {
      OAG_DIRECT, OAG_INDIRECT, OAG_SHORT_IDX, OAG_LONG_IDX, OAG_ZERO_IDX
   } oag_mode_e;

   typedef enum logic [2:0] {
      OAG_S_IDLE, OAG_S_RDREG, OAG_S_CALC, OAG_S_MEM, OAG_S_WB, OAG_S_DONE
   } oag_state_e;

   typedef struct packed {
      oag_mode_e mode;
      logic ext;
      logic byte_op;
      logic [7:0] reg_field;
      logic [23:0] disp;
      logic single_ref;
   } oag_req_s;

   typedef struct packed {
      oag_state_e st;
      oag_req_s q;
      logic ainc;
      logic [7:0] reg_addr;
      logic [31:0] ptr;
      logic req_ready;
      logic rf_rd_en;
      logic mem_req;
      logic [23:0] mem_addr;
      logic mem_byte;
      logic rf_wr_en;
      logic [31:0] rf_wr_data;
      logic done;
      logic err;
      logic direct;
   } oag_regs_s;
endpackage

// >>> oag_addr_gen.sv
// Operand effective-address generator between decoder, register file and memory
`timescale 1ns/10ps
module oag_addr_gen (
   input wire logic clock,
   input wire logic nrst,
   input wire logic req_valid,
   input oag_pkg::oag_req_s req,
   output logic req_ready,
   output logic rf_rd_en,
   output logic [7:0] rf_rd_addr,
   input wire logic [31:0] rf_rd_data,
   output logic mem_req,
   output logic [23:0] mem_addr,
   output logic mem_byte,
   input wire logic mem_ack,
   output logic rf_wr_en,
   output logic [7:0] rf_wr_addr,
   output logic [31:0] rf_wr_data,
   output logic done,
   output logic err,
   output logic direct
);
   oag_pkg::oag_regs_s r_r;
   oag_pkg::oag_regs_s r_nxt;
   logic [31:0] opnd;
   logic [23:0] inc;
   logic [23:0] ea;

   // -----------------------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------------------
   always_comb begin
      r_nxt = r_r;
      r_nxt.rf_rd_en = 1'b0;
      r_nxt.rf_wr_en = 1'b0;
      r_nxt.done = 1'b0;
      r_nxt.err = 1'b0;
      r_nxt.direct = 1'b0;
      // A read of the zero register never reaches the file: it reads as 32 bits of zero
      opnd = (r_r.reg_addr == oag_pkg::ZERO_REG_ADDR) ? 32'h00000000 : rf_rd_data;
      inc = r_r.q.byte_op ? oag_pkg::INC_BYTE : oag_pkg::INC_WORD;
      ea = 24'h000000;
      case (r_r.q.mode)
         oag_pkg::OAG_INDIRECT: begin
            if (r_r.q.ext) begin
               ea = opnd[23:0];
            end else begin
               ea = {oag_pkg::PAGE_ZERO, opnd[15:0]};
            end
         end
         oag_pkg::OAG_SHORT_IDX: begin
            // Wraps within 16 bits so the reach is base plus 0..255
            ea = {oag_pkg::PAGE_ZERO, 16'(opnd[15:0] + {8'h00, r_r.q.disp[7:0]})};
         end
         oag_pkg::OAG_LONG_IDX: begin
            if (r_r.q.ext) begin
               ea = 24'(opnd[23:0] + r_r.q.disp);
            end else begin
               ea = {oag_pkg::PAGE_ZERO, 16'(opnd[15:0] + r_r.q.disp[15:0])};
            end
         end
         oag_pkg::OAG_ZERO_IDX: begin
            if (r_r.q.ext) begin
               ea = r_r.q.disp;
            end else begin
               ea = {oag_pkg::PAGE_ZERO, r_r.q.disp[15:0]};
            end
         end
         default: begin
            ea = 24'h000000;
         end
      endcase
      case (r_r.st)
         oag_pkg::OAG_S_IDLE: begin
            if (req_valid) begin
               r_nxt.q = req;
               r_nxt.req_ready = 1'b0;
               r_nxt.ainc = 1'b0;
               r_nxt.reg_addr = req.reg_field;
               if (req.mode == oag_pkg::OAG_DIRECT) begin
                  // Direct operands live in the lower file and need no memory cycle
                  r_nxt.direct = 1'b1;
                  r_nxt.done = 1'b1;
                  r_nxt.st = oag_pkg::OAG_S_DONE;
               end else if (!req.single_ref) begin
                  r_nxt.err = 1'b1;
                  r_nxt.done = 1'b1;
                  r_nxt.st = oag_pkg::OAG_S_DONE;
               end else begin
                  if (req.mode == oag_pkg::OAG_INDIRECT) begin
                     r_nxt.ainc = req.reg_field[0];
                     r_nxt.reg_addr = req.reg_field & oag_pkg::PTR_FIELD_MASK;
                  end
                  // Test the masked address so a field of 01h never reads the zero register
                  r_nxt.rf_rd_en = (req.mode != oag_pkg::OAG_ZERO_IDX) &&
                                   (r_nxt.reg_addr != oag_pkg::ZERO_REG_ADDR);
                  r_nxt.st = oag_pkg::OAG_S_RDREG;
               end
            end
         end
         oag_pkg::OAG_S_RDREG: begin
            r_nxt.st = oag_pkg::OAG_S_CALC;
         end
         oag_pkg::OAG_S_CALC: begin
            r_nxt.ptr = opnd;
            r_nxt.mem_addr = ea;
            r_nxt.mem_byte = r_r.q.byte_op;
            r_nxt.mem_req = 1'b1;
            r_nxt.st = oag_pkg::OAG_S_MEM;
         end
         oag_pkg::OAG_S_MEM: begin
            if (mem_ack) begin
               r_nxt.mem_req = 1'b0;
               if (r_r.ainc) begin
                  r_nxt.rf_wr_en = 1'b1;
                  if (r_r.q.ext) begin
                     r_nxt.rf_wr_data = {r_r.ptr[31:24], 24'(r_r.ptr[23:0] + inc)};
                  end else begin
                     r_nxt.rf_wr_data = {r_r.ptr[31:16], 16'(r_r.ptr[15:0] + inc[15:0])};
                  end
                  r_nxt.st = oag_pkg::OAG_S_WB;
               end else begin
                  r_nxt.done = 1'b1;
                  r_nxt.st = oag_pkg::OAG_S_DONE;
               end
            end
         end
         oag_pkg::OAG_S_WB: begin
            r_nxt.done = 1'b1;
            r_nxt.st = oag_pkg::OAG_S_DONE;
         end
         oag_pkg::OAG_S_DONE: begin
            r_nxt.req_ready = 1'b1;
            r_nxt.st = oag_pkg::OAG_S_IDLE;
         end
         default: begin
            r_nxt.st = oag_pkg::OAG_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         r_r <= '0;
         r_r.st <= oag_pkg::OAG_S_IDLE;
         r_r.req_ready <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

   // -----------------------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------------------
   assign req_ready = r_r.req_ready;
   assign rf_rd_en = r_r.rf_rd_en;
   assign rf_rd_addr = r_r.reg_addr;
   assign mem_req = r_r.mem_req;
   assign mem_addr = r_r.mem_addr;
   assign mem_byte = r_r.mem_byte;
   assign rf_wr_en = r_r.rf_wr_en;
   assign rf_wr_addr = r_r.reg_addr;
   assign rf_wr_data = r_r.rf_wr_data;
   assign done = r_r.done;
   assign err = r_r.err;
   assign direct = r_r.direct;

   // -----------------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------------
   logic [1:0] acks_r;
   always_ff @(posedge clock) begin
      if (!nrst || done) begin
         acks_r <= 2'h0;
      end else if (mem_req && mem_ack) begin
         acks_r <= 2'(acks_r + 2'h1);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   direct_no_mem_a: assert property (direct |-> !mem_req && acks_r == 2'h0)
      else $error("direct reference used the memory controller");
   one_mem_ref_a: assert property (acks_r <= 2'h1)
      else $error("more than one memory access for one instruction");
   ainc_value_a: assert property (rf_wr_en && !r_r.q.ext |->
      rf_wr_data[15:0] == 16'(r_r.ptr[15:0] + (r_r.q.byte_op ? 16'h0001 : 16'h0002)))
      else $error("autoincrement step wrong");
   ainc_ext_a: assert property (rf_wr_en && r_r.q.ext |->
      rf_wr_data[23:0] == 24'(r_r.ptr[23:0] + (r_r.q.byte_op ? 24'h1 : 24'h2)))
      else $error("extended autoincrement step wrong");
   ptr_lsb_a: assert property (rf_rd_en && r_r.q.mode == oag_pkg::OAG_INDIRECT |->
      !rf_rd_addr[0])
      else $error("autoincrement bit leaked into register address");
   page_zero_a: assert property (mem_req && !r_r.q.ext |-> mem_addr[23:16] == 8'h00)
      else $error("nonextended address left page zero");
   wb_before_done_a: assert property (rf_wr_en |=> done && !rf_wr_en)
      else $error("pointer write-back not followed by done");
   mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("memory request dropped before acknowledge");
   read_to_req_a: assert property ($rose(rf_rd_en) |-> ##2 $rose(mem_req))
      else $error("pointer read not followed by memory request");
   zero_reg_a: assert property (rf_rd_en |-> rf_rd_addr != 8'h00)
      else $error("zero register read from the file");
   zero_idx_a: assert property ($rose(mem_req) && r_r.q.mode == oag_pkg::OAG_ZERO_IDX &&
      r_r.q.ext |-> mem_addr == r_r.q.disp)
      else $error("zero-indexed address differs from instruction address");
   refuse_quiet_a: assert property (err |-> done && !mem_req && acks_r == 2'h0)
      else $error("refused request reached the memory controller");
   ainc_ind_only_a: assert property (rf_wr_en |-> r_r.q.mode == oag_pkg::OAG_INDIRECT && r_r.ainc)
      else $error("pointer written back outside indirect autoincrement");
   short_reach_a: assert property ($rose(mem_req) && r_r.q.mode == oag_pkg::OAG_SHORT_IDX |->
      16'(mem_addr[15:0] - r_r.ptr[15:0]) <= 16'h00ff)
      else $error("short-indexed address beyond 255 bytes from base");

   ainc_ext_c: cover property (rf_wr_en && r_r.q.ext);
   short_idx_c: cover property (mem_req && mem_ack && r_r.q.mode == oag_pkg::OAG_SHORT_IDX);
   direct_c: cover property (direct);
   refuse_c: cover property (err);
   ainc_word_c: cover property (rf_wr_en && !r_r.q.ext);
endmodule

// >>> oag_far_model.sv
// Behavioural register file and memory controller facing the address generator
`timescale 1ns/10ps
module oag_far_model (
   input wire logic clock,
   input wire logic rf_rd_en,
   input wire logic [7:0] rf_rd_addr,
   output logic [31:0] rf_rd_data,
   input wire logic mem_req,
   input wire logic [23:0] mem_addr,
   input wire logic mem_byte,
   output logic mem_ack,
   input wire logic rf_wr_en,
   input wire logic [7:0] rf_wr_addr,
   input wire logic [31:0] rf_wr_data,
   input wire logic [2:0] ack_dly
);
   logic [31:0] rf [256];
   logic [2:0] wait_r = 3'h0;
   logic [23:0] last_addr = 24'h0;
   logic last_byte = 1'b0;
   int acc_cnt = 0;
   initial begin
      rf_rd_data = 32'h0;
      mem_ack = 1'b0;
   end
   // ----
   // Read port and memory handshake
   // ----
   always @(posedge clock) begin
      // Data is only good the cycle after the strobe, scrambled otherwise
      rf_rd_data <= rf_rd_en ? rf[rf_rd_addr] : ~rf_rd_data;
      if (rf_wr_en) begin
         rf[rf_wr_addr] <= rf_wr_data;
      end
      if (mem_req && mem_ack) begin
         last_addr <= mem_addr;
         last_byte <= mem_byte;
         acc_cnt++;
      end
      // Acknowledge after a chosen number of waiting cycles, one cycle wide
      mem_ack <= mem_req && !mem_ack && wait_r >= ack_dly;
      wait_r <= (mem_req && !mem_ack) ? wait_r + 3'h1 : 3'h0;
   end
endmodule

// >>> operand_address_generator_tb_top.sv
// Self-checking bench for the operand address generator
`timescale 1ns/10ps
module operand_address_generator_tb_top;
   logic clock = 0;
   logic nrst = 0;
   logic req_valid = 0;
   oag_pkg::oag_req_s req = '0;
   logic req_ready, rf_rd_en, mem_req, mem_byte, mem_ack, rf_wr_en, done, err, direct;
   logic [7:0] rf_rd_addr, rf_wr_addr;
   logic [31:0] rf_rd_data, rf_wr_data;
   logic [23:0] mem_addr;
   logic [2:0] ack_dly = 0;
   logic [2:0] m;
   logic [15:0] q;
   logic [15:0] lf = 16'h5544;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;
   always #2 clock = ~clock;
   oag_addr_gen uut (
      .clock(clock),
      .nrst(nrst),
      .req_valid(req_valid),
      .req(req),
      .req_ready(req_ready),
      .rf_rd_en(rf_rd_en),
      .rf_rd_addr(rf_rd_addr),
      .rf_rd_data(rf_rd_data),
      .mem_req(mem_req),
      .mem_addr(mem_addr),
      .mem_byte(mem_byte),
      .mem_ack(mem_ack),
      .rf_wr_en(rf_wr_en),
      .rf_wr_addr(rf_wr_addr),
      .rf_wr_data(rf_wr_data),
      .done(done),
      .err(err),
      .direct(direct)
   );
   oag_far_model mdl (
      .clock(clock),
      .rf_rd_en(rf_rd_en),
      .rf_rd_addr(rf_rd_addr),
      .rf_rd_data(rf_rd_data),
      .mem_req(mem_req),
      .mem_addr(mem_addr),
      .mem_byte(mem_byte),
      .mem_ack(mem_ack),
      .rf_wr_en(rf_wr_en),
      .rf_wr_addr(rf_wr_addr),
      .rf_wr_data(rf_wr_data),
      .ack_dly(ack_dly)
   );
   // ----
   // Helpers
   // ----
   function automatic logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction
   function automatic logic [23:0] ea(logic [2:0] md, logic x, logic [23:0] d, logic [31:0] p);
      case (md)
         3'h1: ea = x ? p[23:0] : {8'h00, p[15:0]};
         3'h2: ea = {8'h00, p[15:0] + {8'h00, d[7:0]}};
         default: ea = x ? p[23:0] + d : {8'h00, p[15:0] + d[15:0]};
      endcase
   endfunction
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("mismatch %0t %s", $time, msg);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic one(input logic [2:0] md, input logic x, input logic b, input logic [7:0] f,
                      input logic [23:0] d, input logic s, input logic [31:0] p);
      logic [23:0] a;
      logic [31:0] w;
      int c0;
      int n;
      if (f[7:1] != 7'h0) mdl.rf[{f[7:1], 1'b0}] = p;
      else p = 32'h0;
      a = ea(md, x, d, p);
      w = x ? {p[31:24], p[23:0] + (b ? 24'h1 : 24'h2)} : {p[31:16], p[15:0] + (b ? 16'h1 : 16'h2)};
      c0 = mdl.acc_cnt;
      @(posedge clock);
      #1;
      req = '{oag_pkg::oag_mode_e'(md), x, b, f, d, s};
      ack_dly = {1'b0, lf[1:0]};
      req_valid = 1;
      @(posedge clock);
      #1;
      req_valid = 0;
      for (n = 0; n < 40 && done !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      if (md == 3'h0) begin
         chk(direct === 1'b1 && n == 0 && mdl.acc_cnt == c0, "direct");
      end else if (!s) begin
         chk(err === 1'b1 && n == 0 && mdl.acc_cnt == c0, "refuse");
      end else begin
         chk(mdl.acc_cnt == c0 + 1 && mdl.last_addr === a, "address");
         chk(mdl.last_byte === b && err === 1'b0, "size");
         if (md == 3'h1 && f[0]) chk(mdl.rf[{f[7:1], 1'b0}] === w, "pointer");
         else if (md == 3'h1 && f[7:1] != 7'h0) chk(mdl.rf[{f[7:1], 1'b0}] === p, "no step");
      end
      @(posedge clock);
      #1;
      chk(req_ready === 1'b1, "ready");
   endtask
   // ----
   // Sequence
   // ----
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         $display("mismatch %0t timeout", $time);
         miscompares++;
         stop_test;
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      #1;
      nrst = 1;
      chk(req_ready === 1'b1 && done === 1'b0, "reset");
      // Corners: pointer and offset wrap, stack pointer as base, zero register
      one(3'h1, 0, 0, 8'h19, 24'h0, 1, 32'habcdfffe);
      one(3'h1, 1, 1, 8'h1d, 24'h0, 1, 32'h12ffffff);
      one(3'h2, 0, 0, 8'h18, 24'h0000ff, 1, 32'h0000ff01);
      one(3'h3, 0, 1, 8'h1c, 24'h00ffff, 1, 32'h0);
      one(3'h3, 1, 0, 8'h00, 24'h023456, 1, 32'h0);
      one(3'h4, 0, 0, 8'h00, 24'h001234, 1, 32'h0);
      one(3'h1, 0, 0, 8'h1c, 24'h0, 0, 32'h0);
      one(3'h0, 0, 0, 8'h1c, 24'h0, 1, 32'h0);
      repeat (60) begin
         m = 3'(rnd() % 5);
         q = rnd();
         one(m, m != 3'h2 && q[0], q[1], m == 3'h4 ? 8'h00 : {q[15:9] | 7'h02, m == 3'h1 && q[2]},
             {q[7:0], rnd()}, q[6:3] != 4'h0, {rnd(), rnd()});
      end
      stop_test;
   end
endmodule
